//--- rtl/acl_lookup_policy_match.sv
// Access-control lookup: ternary match, default actions and CPU single-copy gate.
//
// Contract
// R01: Ingress port field is a mask; bit N selects frames from port N.
// R02: Don't-care port bits let several ports share one entry list.
// R03: Policy group tag is eight bits, selecting up to 256 lists.
// R04: Per-port default tag, replaceable by a first classify stage hit.
// R05: Final tag compared to entry tag field; don't-care bits always match.
// R06: Among matches, lowest storage index wins regardless of list kind; code picks the lowest index separately in each list.
// R07: No match in first lookup applies the ingress port default action.
// R08: Second lookup per frame with one shared default action on miss.
// R09: All-zero action leaves normal forwarding and learning unchanged.
// R10: Mask select with empty forwarding mask discards the frame.
// R11: Entries may require ARP qualifier flags from the frame.
// R12: Single-copy gate passes one CPU frame until the CPU re-arms it.
// R13: Without class override the port default QoS class is used.
`timescale 1ns/1ps
`default_nettype none
module acl_lookup_policy_match #(
  parameter int PORTS = acl_lookup_pkg::PORTS,
  parameter int ENTRIES = acl_lookup_pkg::ENTRIES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic frameValid,
  input wire acl_lookup_pkg::frame_s frameIn,
  input wire logic cfgWrite,
  input wire logic [acl_lookup_pkg::IDX_W-1:0] cfgIndex,
  input wire acl_lookup_pkg::entry_s cfgEntry,
  input wire logic portCfgWrite,
  input wire logic [3:0] portCfgIndex,
  input wire logic [acl_lookup_pkg::TAG_W-1:0] portTagCfg,
  input wire logic [acl_lookup_pkg::QOS_W-1:0] portQosCfg,
  input wire acl_lookup_pkg::action_s portDefaultCfg,
  input wire logic secondDefaultWrite,
  input wire acl_lookup_pkg::action_s secondDefaultCfg,
  input wire logic cpuReady,
  output var acl_lookup_pkg::result_s resultOut,
  output logic resultValid,
  output logic gateArmed
);
  acl_lookup_pkg::entry_s tcam[ENTRIES];
  logic [acl_lookup_pkg::TAG_W-1:0] portTag_q[PORTS];
  logic [acl_lookup_pkg::QOS_W-1:0] portQos_q[PORTS];
  acl_lookup_pkg::action_s portDef_q[PORTS];
  acl_lookup_pkg::action_s secondDef_q;
  logic gate_q;
  logic [ENTRIES-1:0] hit1;
  logic [ENTRIES-1:0] hit2;
  logic [acl_lookup_pkg::TAG_W-1:0] finalTag;
  logic [PORTS-1:0] portOneHot;
  acl_lookup_pkg::action_s act1;
  acl_lookup_pkg::action_s act2;
  acl_lookup_pkg::action_s merged;
  logic found1;
  logic found2;
  logic cpuWanted;
  logic cpuGo;
  logic portOk;

  // Entry table writes; entries start invalid so nothing matches after reset.
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < ENTRIES; i++) begin
        tcam[i] <= '0;
      end
    end else if (cfgWrite) begin
      tcam[cfgIndex] <= cfgEntry;
    end
  end

  // Per-port tag, class and default action settings.
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < PORTS; i++) begin
        portTag_q[i] <= acl_lookup_pkg::TAG_RESET; // see R04
        portQos_q[i] <= acl_lookup_pkg::QOS_RESET;
        portDef_q[i] <= '0;
      end
    end else if (portCfgWrite && (32'(portCfgIndex) < PORTS)) begin
      portTag_q[portCfgIndex] <= portTagCfg;
      portQos_q[portCfgIndex] <= portQosCfg;
      portDef_q[portCfgIndex] <= portDefaultCfg;
    end
  end

  // Shared default for the second lookup.
  always_ff @(posedge clk) begin
    if (reset) begin
      secondDef_q <= '0;
    end else if (secondDefaultWrite) begin
      secondDef_q <= secondDefaultCfg; // see R08
    end
  end

  // Classifier override replaces the port default tag.
  always_comb begin
    portOk = 32'(frameIn.port) < PORTS;
    finalTag = frameIn.tagOverride ? frameIn.tag
             : (portOk ? portTag_q[frameIn.port] : acl_lookup_pkg::TAG_RESET); // see R04
    portOneHot = portOk ? PORTS'(1) << frameIn.port : '0; // see R01
  end

  // Ternary compare of each entry, one copy per entry.
  for (genvar e = 0; e < ENTRIES; e++) begin : g_match
    logic pm;
    logic tm;
    logic am;
    // A cared port bit must be set for the frame's port; uncared bits match any port.
    assign pm = ((portOneHot & tcam[e].portCare & ~tcam[e].portSel) == '0)
             && ((portOneHot & ~tcam[e].portCare) != '0
                 || (portOneHot & tcam[e].portSel) != '0); // see R01 R02
    assign tm = ((finalTag ^ tcam[e].tagVal) & tcam[e].tagCare) == '0; // see R03 R05
    assign am = (tcam[e].arpNeed & ~frameIn.arpFlags) == '0; // see R11
    assign hit1[e] = tcam[e].valid && !tcam[e].second && pm && tm && am;
    assign hit2[e] = tcam[e].valid && tcam[e].second && pm && tm && am;
  end

  // Lowest index wins within each lookup; first and second lists are resolved separately.
  always_comb begin
    found1 = 1'b0;
    found2 = 1'b0;
    act1 = portOk ? portDef_q[frameIn.port] : '0; // see R07
    act2 = secondDef_q; // see R08
    for (int e = ENTRIES - 1; e >= 0; e--) begin
      if (hit1[e]) begin
        act1 = tcam[e].act; // see R06
        found1 = 1'b1;
      end
      if (hit2[e]) begin
        act2 = tcam[e].act;
        found2 = 1'b1;
      end
    end
  end

  // Combine lookups: a discard from either wins, CPU copy from either is kept.
  // A single-copy flag on its own is a gated CPU redirect, so it asks for a copy too.
  always_comb begin
    merged = '0;
    merged.maskSel = act1.maskSel | act2.maskSel;
    merged.fwdMask = (act1.maskSel ? act1.fwdMask : {PORTS{1'b1}})
                   & (act2.maskSel ? act2.fwdMask : {PORTS{1'b1}});
    merged.cpuCopy = act1.cpuCopy | act1.singleCopy | act2.cpuCopy | act2.singleCopy; // see R12
    merged.singleCopy = (act1.cpuCopy | act1.singleCopy) ? act1.singleCopy : act2.singleCopy;
    merged.cpuQueue = (act1.cpuCopy | act1.singleCopy) ? act1.cpuQueue : act2.cpuQueue;
    cpuWanted = frameValid && merged.cpuCopy;
    cpuGo = cpuWanted && (!merged.singleCopy || gate_q); // see R12
  end

  // Single-copy gate: closes on a passed copy, CPU ready re-arms; re-arm wins.
  always_ff @(posedge clk) begin
    if (reset) begin
      gate_q <= 1'b1;
    end else if (cpuReady) begin
      gate_q <= 1'b1; // see R12
    end else if (cpuGo && merged.singleCopy) begin
      gate_q <= 1'b0; // see R12
    end
  end

  // Registered decision toward forwarding logic.
  always_ff @(posedge clk) begin
    if (reset) begin
      resultOut <= '0;
      resultValid <= 1'b0;
      gateArmed <= 1'b1;
    end else begin
      resultValid <= frameValid;
      gateArmed <= cpuReady | (gate_q & ~(cpuGo & merged.singleCopy));
      resultOut.keepNormal <= !merged.maskSel; // see R09
      resultOut.discard <= merged.maskSel && (merged.fwdMask == acl_lookup_pkg::MASK_ZERO); // see R10
      resultOut.fwdMask <= merged.maskSel ? merged.fwdMask : {PORTS{1'b1}};
      resultOut.cpuCopy <= cpuGo;
      resultOut.cpuQueue <= merged.cpuQueue;
      resultOut.tag <= finalTag;
      resultOut.qos <= frameIn.qosOverride ? frameIn.qos
                     : (portOk ? portQos_q[frameIn.port] : acl_lookup_pkg::QOS_RESET); // see R13
    end
  end

  a_discard_empty: assert property (@(posedge clk) disable iff (reset)
    frameValid && merged.maskSel && merged.fwdMask == '0 |=> resultOut.discard && resultValid)
    else $error("empty mask did not discard"); // see R10
  a_zero_keep: assert property (@(posedge clk) disable iff (reset)
    frameValid && !found1 && !found2 && portDef_q[frameIn.port] == '0 && secondDef_q == '0 && portOk
    |=> resultOut.keepNormal && !resultOut.cpuCopy)
    else $error("zero action changed forwarding"); // see R09
  sequence s_copy_taken;
    cpuGo && merged.singleCopy && !cpuReady;
  endsequence
  a_gate_single: assert property (@(posedge clk) disable iff (reset)
    s_copy_taken ##1 !cpuReady |-> !gate_q)
    else $error("gate passed a second copy"); // see R12
  a_gate_rearm: assert property (@(posedge clk) disable iff (reset)
    cpuReady |=> gate_q && gateArmed)
    else $error("ready did not re-arm gate"); // see R12
  a_qos_default: assert property (@(posedge clk) disable iff (reset)
    frameValid && !frameIn.qosOverride && portOk |=> resultOut.qos == $past(portQos_q[frameIn.port]))
    else $error("default class not applied"); // see R13
  a_tag_select: assert property (@(posedge clk) disable iff (reset)
    frameValid && frameIn.tagOverride |=> resultOut.tag == $past(frameIn.tag))
    else $error("classifier tag not used"); // see R04
  a_first_default: assert property (@(posedge clk) disable iff (reset)
    portOk && !found1 |-> act1 == portDef_q[frameIn.port])
    else $error("port default not applied"); // see R07
  a_second_default: assert property (@(posedge clk) disable iff (reset)
    !found2 |-> act2 == secondDef_q)
    else $error("shared default not applied"); // see R08
  a_priority_low: assert property (@(posedge clk) disable iff (reset)
    hit1[0] |-> act1 == tcam[0].act)
    else $error("lowest entry did not win"); // see R06
endmodule // acl_lookup_policy_match
`default_nettype wire

//--- rtl/acl_lookup_pkg.sv
// Shared constants and carrier types for the access-control lookup block.
package acl_lookup_pkg;
  localparam int PORTS = 11;
  localparam int TAG_W = 8;
  localparam int QOS_W = 3;
  localparam int QUEUE_W = 3;
  localparam int ENTRIES = 16;
  localparam int IDX_W = 4;
  localparam int ARP_W = 5;
  // ARP qualifier bit positions.
  localparam int ARP_L2BC = 0;
  localparam int ARP_HW_ETH = 1;
  localparam int ARP_PROTO_IP = 2;
  localparam int ARP_LEN_OK = 3;
  localparam int ARP_SENDER_OK = 4;
  localparam logic [TAG_W-1:0] TAG_RESET = 8'h00;
  localparam logic [QOS_W-1:0] QOS_RESET = 3'h0;
  localparam logic [PORTS-1:0] MASK_ZERO = 11'h000;

  // Action vector; all-zero means leave normal forwarding alone.
  typedef struct packed {
    logic maskSel;
    logic [PORTS-1:0] fwdMask;
    logic cpuCopy;
    logic singleCopy;
    logic [QUEUE_W-1:0] cpuQueue;
  } action_s;

  // Ternary entry: value and care masks per field, plus lookup select.
  typedef struct packed {
    logic valid;
    logic second;
    logic [PORTS-1:0] portCare;
    logic [PORTS-1:0] portSel;
    logic [TAG_W-1:0] tagVal;
    logic [TAG_W-1:0] tagCare;
    logic [ARP_W-1:0] arpNeed;
    action_s act;
  } entry_s;

  // Frame descriptor entering the lookup.
  typedef struct packed {
    logic [3:0] port;
    logic tagOverride;
    logic [TAG_W-1:0] tag;
    logic qosOverride;
    logic [QOS_W-1:0] qos;
    logic [ARP_W-1:0] arpFlags;
  } frame_s;

  // Decision handed to forwarding logic.
  typedef struct packed {
    logic discard;
    logic keepNormal;
    logic [PORTS-1:0] fwdMask;
    logic cpuCopy;
    logic [QUEUE_W-1:0] cpuQueue;
    logic [QOS_W-1:0] qos;
    logic [TAG_W-1:0] tag;
  } result_s;
endpackage

//--- testbench/cpu_ready_model.sv
// Behavioural CPU that re-arms the single-copy gate after a chosen delay.
`timescale 1ns/1ps
`default_nettype none
module cpu_ready_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic gateArmed,
  input wire logic [3:0] delay,
  output logic cpuReady
);
  logic [3:0] waitCount_q;
  // A slow CPU keeps the gate shut for a while, so later copies must be held back.
  always_ff @(posedge clk) begin
    if (reset) begin
      waitCount_q <= 4'h0;
      cpuReady <= 1'b0;
    end else begin
      cpuReady <= 1'b0;
      if (!gateArmed && waitCount_q >= delay) begin
        cpuReady <= 1'b1;
        waitCount_q <= 4'h0;
      end else if (!gateArmed) begin
        waitCount_q <= waitCount_q + 4'h1;
      end
    end
  end
endmodule // cpu_ready_model
`default_nettype wire

//--- testbench/acl_lookup_policy_match_tb.sv
// Self-checking bench for the access-control lookup with a reference model and scoreboard.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module acl_lookup_policy_match_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic frameValid = 1'b0, cfgWrite = 1'b0, portCfgWrite = 1'b0, secondDefaultWrite = 1'b0, lastFv = 1'b0;
  logic cpuReady, resultValid, gateArmed, armed, anySel;
  logic [3:0] cfgIndex = 4'h0, portCfgIndex = 4'h0, delay = 4'h0;
  logic [7:0] portTagCfg = 8'h00, tg;
  logic [2:0] portQosCfg = 3'h0;
  acl_lookup_pkg::frame_s frameIn = '0, fr;
  acl_lookup_pkg::entry_s cfgEntry = '0, ne;
  acl_lookup_pkg::entry_s ent [16];
  acl_lookup_pkg::action_s portDefaultCfg = '0, secondDefaultCfg = '0, sdef, a1, a2, c;
  acl_lookup_pkg::action_s pdef [16];
  logic [7:0] tagCfg [16];
  logic [2:0] qosCfg [16];
  acl_lookup_pkg::result_s resultOut, e;
  logic [$bits(acl_lookup_pkg::result_s):0] expQ [$];
  logic [$bits(acl_lookup_pkg::result_s):0] expV;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;

  always #2.5 clk = ~clk;

  acl_lookup_policy_match u_dut (.clk(clk), .reset(reset), .frameValid(frameValid), .frameIn(frameIn),
    .cfgWrite(cfgWrite), .cfgIndex(cfgIndex), .cfgEntry(cfgEntry), .portCfgWrite(portCfgWrite),
    .portCfgIndex(portCfgIndex), .portTagCfg(portTagCfg), .portQosCfg(portQosCfg),
    .portDefaultCfg(portDefaultCfg), .secondDefaultWrite(secondDefaultWrite),
    .secondDefaultCfg(secondDefaultCfg), .cpuReady(cpuReady), .resultOut(resultOut),
    .resultValid(resultValid), .gateArmed(gateArmed));
  cpu_ready_model u_cpu (.clk(clk), .reset(reset), .gateArmed(gateArmed), .delay(delay), .cpuReady(cpuReady));

  // Lowest index wins; a miss falls back to the port or shared default action.
  function automatic acl_lookup_pkg::action_s look(acl_lookup_pkg::frame_s f, logic [7:0] t, logic sec);
    for (int i = 0; i < 16; i++) begin
      if (ent[i].valid && ent[i].second == sec && (!ent[i].portCare[f.port] || ent[i].portSel[f.port])
          && ((t ^ ent[i].tagVal) & ent[i].tagCare) == 8'h00 && (ent[i].arpNeed & ~f.arpFlags) == 5'h00) begin
        return ent[i].act;
      end
    end
    return sec ? sdef : pdef[f.port];
  endfunction

  // Short actions with empty masks and all-zero vectors appear often on purpose.
  function automatic acl_lookup_pkg::action_s rand_act();
    acl_lookup_pkg::action_s a;
    a = 17'($urandom);
    if ($urandom % 3 == 0) a.fwdMask = 11'h000;
    if ($urandom % 3 == 0) a = '0;
    return a;
  endfunction

  // Reference model: predicts each decision and the gate, then mirrors config writes.
  always @(posedge clk) begin
    if (reset) begin
      armed = 1'b1;
      sdef = '0;
      for (int i = 0; i < 16; i++) begin
        ent[i] = '0;
        pdef[i] = '0;
        tagCfg[i] = 8'h00;
        qosCfg[i] = 3'h0;
      end
    end else begin
      if (frameValid) begin
        tg = frameIn.tagOverride ? frameIn.tag : tagCfg[frameIn.port];
        a1 = look(frameIn, tg, 1'b0);
        a2 = look(frameIn, tg, 1'b1);
        anySel = a1.maskSel | a2.maskSel;
        e.fwdMask = (a1.maskSel ? a1.fwdMask : 11'h7FF) & (a2.maskSel ? a2.fwdMask : 11'h7FF);
        e.discard = anySel && e.fwdMask == 11'h000;
        e.keepNormal = !anySel;
        c = (a1.cpuCopy | a1.singleCopy) ? a1 : a2;
        e.cpuCopy = (c.cpuCopy | c.singleCopy) && (!c.singleCopy || armed);
        e.cpuQueue = c.cpuQueue;
        e.qos = frameIn.qosOverride ? frameIn.qos : qosCfg[frameIn.port];
        e.tag = tg;
        armed = cpuReady | (armed & !(e.cpuCopy & c.singleCopy));
        expQ.push_back({e, armed});
      end else begin
        armed = armed | cpuReady;
      end
      if (cfgWrite) ent[cfgIndex] = cfgEntry;
      if (portCfgWrite && portCfgIndex < 4'hB) begin
        tagCfg[portCfgIndex] = portTagCfg;
        qosCfg[portCfgIndex] = portQosCfg;
        pdef[portCfgIndex] = portDefaultCfg;
      end
      if (secondDefaultWrite) sdef = secondDefaultCfg;
    end
  end

  // Monitor: the answer must come exactly one cycle after each frame and match the oldest note.
  always @(posedge clk) begin
    lastFv <= frameValid && !reset;
    if (!reset) begin
      `CHK(resultValid, lastFv)
      // Pop once into a variable so a mismatch report cannot consume a second note.
      if (resultValid === 1'b1 && expQ.size() > 0) begin
        expV = expQ.pop_front();
        `CHK({resultOut, gateArmed}, expV)
      end
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The run needs about 3000 cycles; anything far past that is a hang.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 8000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // Random traffic, back to back at times, with config changes racing the frames.
  initial begin
    void'($urandom(32'h2734));
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK(gateArmed, 1'b1)
    repeat (3000) begin
      @(posedge clk);
      fr = 22'($urandom);
      fr.port = 4'($urandom % 11);
      fr.tag = 8'($urandom % 4);
      frameIn <= fr;
      frameValid <= ($urandom % 4) != 0;
      ne = 62'({$urandom, $urandom});
      ne.tagVal = 8'($urandom % 4);
      ne.arpNeed = ne.arpNeed & 5'($urandom);
      ne.act = rand_act();
      cfgEntry <= ne;
      cfgIndex <= 4'($urandom);
      cfgWrite <= ($urandom % 6) == 0;
      portCfgWrite <= ($urandom % 6) == 0;
      portCfgIndex <= 4'($urandom);
      portTagCfg <= 8'($urandom % 4);
      portQosCfg <= 3'($urandom);
      portDefaultCfg <= rand_act();
      secondDefaultWrite <= ($urandom % 20) == 0;
      secondDefaultCfg <= rand_act();
      delay <= 4'($urandom);
    end
    @(posedge clk);
    frameValid <= 1'b0;
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule // acl_lookup_policy_match_tb
`default_nettype wire
